//--- design/buck_ctrl_defs.svh
// Register offsets, field positions and reset values of the buck converter control bank
`ifndef BUCK_CTRL_DEFS_SVH
`define BUCK_CTRL_DEFS_SVH

`define BUCK1_CONTROL_ADDR    8'h0C
`define BUCK2_CONTROL_ADDR    8'h0D
`define BUCK3_CONTROL_ADDR    8'h0E

`define BIT_ENABLE            0
`define BIT_PIN_SELECT        1
`define BIT_RESERVED_LOW      2
`define BIT_AUTO_DISCHARGE    3
`define BIT_POWER_GOOD        4
`define BIT_OVERTEMP          5
`define BIT_OVERCURRENT       6
`define BIT_RESERVED_HIGH     7

`define BUCK_CONTROL_RESET    8'h8E
`define RESET_ENABLE          1'h0
`define RESET_PIN_SELECT      1'h1
`define RESET_AUTO_DISCHARGE  1'h1
`define RESERVED_READ         1'h1
`define UNMAPPED_READ         8'h00
`define RESET_FLAG            1'h0

`endif

//--- design/buck_ctrl_pkg.sv
// Types shared by the buck converter control register bank
package buck_ctrl_pkg;

  typedef logic [7:0] ctrl_byte_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [2:0] conv_vec_t;

endpackage : buck_ctrl_pkg

//--- design/buck_converter_control_regs.sv
// Control and status registers for three buck converters
//
// Behaviour
// - Pin-select bit set: the converter's external enable pin decides whether it runs.
// - Pin-select bit clear: ignore the external pin, run from register enable only.
// - Bit 5 reads 1 while overtemperature is detected, else 0; read only.
// - Bit 4 reads 1 while the output voltage is good, else 0; read only.
`timescale 1ns/100ps
`include "buck_ctrl_defs.svh"

module buck_converter_control_regs
  import buck_ctrl_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire reg_addr_t  reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire ctrl_byte_t reg_wdata_i,
  input  wire logic       reg_rd_i,
  output ctrl_byte_t      reg_rdata_o,
  input  wire conv_vec_t  overcurrent_flag_i,
  input  wire conv_vec_t  overtemperature_flag_i,
  input  wire conv_vec_t  power_good_flag_i,
  input  wire conv_vec_t  buck_enable_pin_i,
  output conv_vec_t       buck_run_o,
  output conv_vec_t       buck_discharge_o
);

  // One-hot hit on the three control registers
  function automatic conv_vec_t addr_hit(input reg_addr_t a);
    addr_hit = {a == `BUCK3_CONTROL_ADDR, a == `BUCK2_CONTROL_ADDR, a == `BUCK1_CONTROL_ADDR};
  endfunction : addr_hit

  conv_vec_t  enable;
  conv_vec_t  external_pin_control_select;
  conv_vec_t  output_auto_discharge_enable;
  conv_vec_t  overcurrent_flag;
  conv_vec_t  overtemperature_flag;
  conv_vec_t  power_good_flag;
  conv_vec_t  next_run;
  conv_vec_t  wr_hit;
  conv_vec_t  rd_hit;
  ctrl_byte_t next_rdata;

  assign wr_hit = reg_wr_i ? addr_hit(reg_addr_i) : 3'h0;
  assign rd_hit = addr_hit(reg_addr_i);

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_conv

      // Only enable, pin select and auto-discharge take writes
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          enable[i]                       <= `RESET_ENABLE;
          external_pin_control_select[i]  <= `RESET_PIN_SELECT;
          output_auto_discharge_enable[i] <= `RESET_AUTO_DISCHARGE;
        end else if (wr_hit[i]) begin
          enable[i]                       <= reg_wdata_i[`BIT_ENABLE];
          external_pin_control_select[i]  <= reg_wdata_i[`BIT_PIN_SELECT];
          output_auto_discharge_enable[i] <= reg_wdata_i[`BIT_AUTO_DISCHARGE];
        end
      end

      // Status flags follow the converter's monitors
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          overcurrent_flag[i]     <= `RESET_FLAG;
          overtemperature_flag[i] <= `RESET_FLAG;
          power_good_flag[i]      <= `RESET_FLAG;
        end else begin
          overcurrent_flag[i]     <= overcurrent_flag_i[i];
          overtemperature_flag[i] <= overtemperature_flag_i[i];
          power_good_flag[i]      <= power_good_flag_i[i];
        end
      end

      // Pin select hands the on/off decision to the external pin
      always_comb begin
        if (external_pin_control_select[i]) begin
          next_run[i] = buck_enable_pin_i[i];
        end else begin
          next_run[i] = enable[i];
        end
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          buck_run_o[i]       <= 1'h0;
          buck_discharge_o[i] <= 1'h0;
        end else begin
          buck_run_o[i]       <= next_run[i];
          buck_discharge_o[i] <= !next_run[i] && output_auto_discharge_enable[i];
        end
      end

      pin_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        external_pin_control_select[i] |=> buck_run_o[i] == $past(buck_enable_pin_i[i]))
        else $error("run does not follow external pin while selected");

      pin_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !external_pin_control_select[i] |=> buck_run_o[i] == $past(enable[i]))
        else $error("run does not follow enable bit while pin is ignored");

      overtemp_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_rd_i && rd_hit[i] ##1 !rst_i |->
        reg_rdata_o[`BIT_OVERTEMP] == $past(overtemperature_flag_i[i], 2))
        else $error("overtemperature bit does not match monitor");

      power_good_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_rd_i && rd_hit[i] ##1 !rst_i |->
        reg_rdata_o[`BIT_POWER_GOOD] == $past(power_good_flag_i[i], 2))
        else $error("power good bit does not match monitor");

      discharge_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        buck_discharge_o[i] |-> !buck_run_o[i])
        else $error("discharge active while converter runs");

      discharge_when_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !external_pin_control_select[i] && !enable[i] && output_auto_discharge_enable[i]
        |=> buck_discharge_o[i])
        else $error("disabled converter with auto-discharge is not discharging");

      write_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_hit[i] && !reg_wdata_i[`BIT_PIN_SELECT] ##1 !wr_hit[i] |=>
        buck_run_o[i] == $past(reg_wdata_i[`BIT_ENABLE], 2))
        else $error("written enable bit does not steer the converter");

      // Control fields change only through a write to their own register
      field_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_hit[i] |=>
        enable[i] == $past(reg_wdata_i[`BIT_ENABLE]) &&
        external_pin_control_select[i] == $past(reg_wdata_i[`BIT_PIN_SELECT]) &&
        output_auto_discharge_enable[i] == $past(reg_wdata_i[`BIT_AUTO_DISCHARGE]))
        else $error("written control fields were not stored");

      field_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_hit[i] |=>
        $stable(enable[i]) && $stable(external_pin_control_select[i]) &&
        $stable(output_auto_discharge_enable[i]))
        else $error("control fields changed without a write");

      control_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        reg_rd_i && rd_hit[i] |=>
        reg_rdata_o[`BIT_ENABLE] == $past(enable[i]) &&
        reg_rdata_o[`BIT_PIN_SELECT] == $past(external_pin_control_select[i]) &&
        reg_rdata_o[`BIT_AUTO_DISCHARGE] == $past(output_auto_discharge_enable[i]))
        else $error("control fields do not read back");

      overcurrent_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |->
        overcurrent_flag[i] == $past(overcurrent_flag_i[i]))
        else $error("overcurrent flag does not follow its monitor");

      overtemp_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |->
        overtemperature_flag[i] == $past(overtemperature_flag_i[i]))
        else $error("overtemperature flag does not follow its monitor");

      power_good_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |->
        power_good_flag[i] == $past(power_good_flag_i[i]))
        else $error("power good flag does not follow its monitor");

      discharge_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        external_pin_control_select[i] && !buck_enable_pin_i[i] &&
        output_auto_discharge_enable[i] |=> buck_discharge_o[i])
        else $error("pin-controlled converter with auto-discharge is not discharging");

      run_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !external_pin_control_select[i] && enable[i] |=>
        buck_run_o[i] && !buck_discharge_o[i])
        else $error("enabled converter under register control is not running");

      discharge_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !output_auto_discharge_enable[i] |=> !buck_discharge_o[i])
        else $error("discharge active with auto-discharge cleared");
    end
  endgenerate

  // Read image; reserved bits read as their reset value, unmapped reads as zero
  always_comb begin
    next_rdata = `UNMAPPED_READ;
    for (int k = 0; k < 3; k++) begin
      if (rd_hit[k]) begin
        next_rdata[`BIT_RESERVED_HIGH]  = `RESERVED_READ;
        next_rdata[`BIT_OVERCURRENT]    = overcurrent_flag[k];
        next_rdata[`BIT_OVERTEMP]       = overtemperature_flag[k];
        next_rdata[`BIT_POWER_GOOD]     = power_good_flag[k];
        next_rdata[`BIT_AUTO_DISCHARGE] = output_auto_discharge_enable[k];
        next_rdata[`BIT_RESERVED_LOW]   = `RESERVED_READ;
        next_rdata[`BIT_PIN_SELECT]     = external_pin_control_select[k];
        next_rdata[`BIT_ENABLE]         = enable[k];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= `UNMAPPED_READ;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Register port checks
  rdata_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && rd_hit == 3'h0 |=> reg_rdata_o == `UNMAPPED_READ)
    else $error("unmapped read did not return zero");

  reserved_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && rd_hit != 3'h0 |=>
    reg_rdata_o[`BIT_RESERVED_HIGH] && reg_rdata_o[`BIT_RESERVED_LOW])
    else $error("reserved bits did not read as one");

  write_refused_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_wr_i && addr_hit(reg_addr_i) == 3'h0 |=>
    $stable(enable) && $stable(external_pin_control_select) &&
    $stable(output_auto_discharge_enable))
    else $error("write to an unmapped address changed a control field");

endmodule : buck_converter_control_regs

//--- bench/tb_top.sv
// Self-checking testbench for the buck converter control register bank
`timescale 1ns/100ps
`include "buck_ctrl_defs.svh"

module tb_top
  import buck_ctrl_pkg::*;
;
  logic       clk_i;
  logic       rst_i;
  reg_addr_t  addr;
  logic       wr_stb;
  ctrl_byte_t wdata;
  logic       rd_stb;
  ctrl_byte_t rdata;
  conv_vec_t  oc, ot, pg, pin, run, dis;
  int         failures;
  int         num_checks;

  buck_converter_control_regs uut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wr_i(wr_stb),
    .reg_wdata_i(wdata), .reg_rd_i(rd_stb), .reg_rdata_o(rdata),
    .overcurrent_flag_i(oc), .overtemperature_flag_i(ot), .power_good_flag_i(pg),
    .buck_enable_pin_i(pin), .buck_run_o(run), .buck_discharge_o(dis)
  );

  task automatic check8(input ctrl_byte_t got, input ctrl_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t read %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check3(input conv_vec_t got, input conv_vec_t exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t outputs %b expected %b", $time, got, exp);
    end
  endtask : check3

  // Called at a falling edge; strobe stands for one rising edge, then one idle edge
  task automatic wr(input reg_addr_t a, input ctrl_byte_t d);
    addr = a;
    wdata = d;
    wr_stb = 1'h1;
    @(negedge clk_i);
    wr_stb = 1'h0;
    @(negedge clk_i);
  endtask : wr

  task automatic rd(input reg_addr_t a, input ctrl_byte_t exp);
    addr = a;
    rd_stb = 1'h1;
    @(negedge clk_i);
    rd_stb = 1'h0;
    check8(rdata, exp);
    @(negedge clk_i);
  endtask : rd

  task automatic outs(input conv_vec_t exp_run, input conv_vec_t exp_dis);
    check3(run, exp_run);
    check3(dis, exp_dis);
  endtask : outs

  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Whole sequence needs well under 100 cycles
  initial begin
    #5000;
    failures++;
    conclude();
  end

  initial begin
    {rst_i, wr_stb, rd_stb, addr, wdata} = {1'h1, 2'h0, 8'h00, 8'h00};
    {oc, ot, pg, pin} = 12'h000;
    repeat (12) @(negedge clk_i);
    rst_i = 1'h0;
    @(negedge clk_i);
    outs(3'h0, 3'h7);
    rd(`BUCK1_CONTROL_ADDR, `BUCK_CONTROL_RESET);
    rd(`BUCK2_CONTROL_ADDR, `BUCK_CONTROL_RESET);
    rd(`BUCK3_CONTROL_ADDR, `BUCK_CONTROL_RESET);
    pin = 3'h5;
    repeat (2) @(negedge clk_i);
    outs(3'h5, 3'h2);
    pin = 3'h7;
    wr(`BUCK1_CONTROL_ADDR, 8'h09);
    wr(`BUCK2_CONTROL_ADDR, 8'h08);
    wr(`BUCK3_CONTROL_ADDR, 8'hFF);
    @(negedge clk_i);
    outs(3'h5, 3'h2);
    pin = 3'h0;
    repeat (2) @(negedge clk_i);
    outs(3'h1, 3'h6);
    wr(8'h0F, 8'hFF);
    rd(8'h0F, `UNMAPPED_READ);
    {oc, ot, pg} = 9'h054;
    @(negedge clk_i);
    rd(`BUCK1_CONTROL_ADDR, 8'hCD);
    rd(`BUCK2_CONTROL_ADDR, 8'hAC);
    rd(`BUCK3_CONTROL_ADDR, 8'h9F);
    {oc, ot, pg} = 9'h000;
    @(negedge clk_i);
    rd(`BUCK1_CONTROL_ADDR, 8'h8D);
    rd(`BUCK2_CONTROL_ADDR, 8'h8C);
    rd(`BUCK3_CONTROL_ADDR, 8'h8F);
    // Reset in mid-run clears the outputs and restores the register values
    rst_i = 1'h1;
    @(negedge clk_i);
    outs(3'h0, 3'h0);
    check8(rdata, `UNMAPPED_READ);
    rst_i = 1'h0;
    @(negedge clk_i);
    outs(3'h0, 3'h7);
    rd(`BUCK1_CONTROL_ADDR, `BUCK_CONTROL_RESET);
    conclude();
  end
endmodule : tb_top
